// file: core/ros_hyst_cmp.sv
`timescale 1ns/10ps
// Threshold comparator with hysteresis; all quantities in tenths of a percent.
module ros_hyst_cmp
	import ros_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [15:0] level,
	input wire logic [15:0] threshold,
	input wire logic [15:0] hysteresis,
	output logic above
);
	logic above_ff;
	logic nxt_above;
	wire logic [16:0] upper = {1'b0, threshold} + {1'b0, hysteresis};
	wire logic [16:0] lower = {1'b0, threshold} - {1'b0, hysteresis};
	wire logic under_lower = lower[16] ? 1'b0 : ({1'b0, level} < lower);
	wire logic over_upper = {1'b0, level} > upper;

	// The state flips only once the level has crossed the whole band.
	assign nxt_above = above_ff ? !under_lower : over_upper;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			above_ff <= 1'b0;
		end else begin
			above_ff <= nxt_above;
		end
	end

	assign above = above_ff;
endmodule

// file: core/ros_pkg.sv
package ros_pkg;
	// Register offsets on the plain register port (word index).
	localparam logic [3:0] ADDR_SCALE = 4'h0;
	localparam logic [3:0] ADDR_OFFSET = 4'h1;
	localparam logic [3:0] ADDR_RELAY_SEL = 4'h2;
	localparam logic [3:0] ADDR_THRESH = 4'h3;
	localparam logic [3:0] ADDR_HYST = 4'h4;
	localparam logic [3:0] ADDR_CTRL_SRC = 4'h5;
	localparam logic [3:0] ADDR_RESULT = 4'h6;
	localparam logic [3:0] ADDR_SLAVE_SPD = 4'h7;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	// Values in tenths of a percent (or tenths of a Hz for speeds).
	localparam logic [15:0] SCALE_MAX = 16'h4E20;
	localparam logic [15:0] SCALE_RST = 16'h03E8;
	localparam logic [15:0] OFFSET_MAX = 16'h1388;
	localparam logic [15:0] OFFSET_MIN = 16'hEC78;
	localparam logic [15:0] OFFSET_RST = 16'h0000;
	localparam logic [15:0] RELAY_SEL_MAX = 16'h0009;
	localparam logic [15:0] RELAY_SEL_RST = 16'h0001;
	localparam logic [15:0] THRESH_MAX = 16'h07D0;
	localparam logic [15:0] THRESH_RST = 16'h03E8;
	localparam logic [15:0] HYST_MAX = 16'h03E8;
	localparam logic [15:0] HYST_RST = 16'h0000;
	localparam logic [15:0] CTRL_SRC_RST = 16'h0000;
	localparam logic [15:0] CTRL_SRC_SLAVE = 16'h0009;
	// Scaling factor is in tenths of a percent, so 100.0 % divides by 1000.
	localparam logic [31:0] SCALE_UNITY = 32'h000003E8;
	localparam int RESULT_W = 16;
	typedef enum logic [3:0] {
		ROS_RUNNING = 4'h0,
		ROS_HEALTHY = 4'h1,
		ROS_AT_SPEED = 4'h2,
		ROS_TRIPPED = 4'h3,
		ROS_FREQ_HI = 4'h4,
		ROS_CURR_HI = 4'h5,
		ROS_FREQ_LO = 4'h6,
		ROS_CURR_LO = 4'h7,
		ROS_AIN2_HI = 4'h8,
		ROS_READY = 4'h9
	} ros_relay_sel_t;
endpackage

// file: core/ros_relay_scale.sv
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
// Summary of operation
// - Result equals applied level minus offset, times scaling factor.
// - Scaling factor holds 0.0 to 2000.0 percent, resets to 100.0.
// - Offset holds -500.0 to 500.0 percent, resets to 0.0.
// - Slave source 9: speed is master speed times factor, clamped.
// - Scaled result is readable in a read-only result register.
// - Relay select holds 0 to 9, resets to 1.
// - Selected condition true closes the relay contact.
// - Select 0: relay follows motor enabled.
// - Select 1: relay follows power present and no fault.
// - Select 2: relay follows output at setpoint frequency.
// - Select 3: relay follows drive fault.
// - Select 4: relay on while output frequency exceeds threshold.
// - Select 5: relay on while motor current exceeds threshold.
// - Select 6: relay on while output frequency is below threshold.
// - Select 7: relay on while motor current is below threshold.
// - Select 8: relay on while analog input 2 exceeds threshold.
// - Select 9: relay on while drive is ready and not tripped.
// - Threshold holds 0.0 to 200.0 percent, resets to 100.0.
// - Hysteresis 0.0 to 100.0 percent widens the threshold band.
module ros_relay_scale
	import ros_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic [15:0] ain1_level,
	input wire logic [15:0] ain2_level,
	input wire logic [15:0] out_freq_pct,
	input wire logic [15:0] motor_curr_pct,
	input wire logic [15:0] master_speed,
	input wire logic [15:0] min_speed,
	input wire logic [15:0] max_speed,
	input wire logic drive_running,
	input wire logic power_ok,
	input wire logic drive_fault,
	input wire logic at_speed,
	input wire logic drive_ready,
	output logic relay_active,
	output logic [15:0] scaled_analog_result,
	output logic [15:0] slave_speed
);
	logic [15:0] scale_ff;
	logic [15:0] offset_ff;
	logic [15:0] relay_sel_ff;
	logic [15:0] thresh_ff;
	logic [15:0] hyst_ff;
	logic [15:0] ctrl_src_ff;
	logic [15:0] result_ff;
	logic [15:0] slave_ff;
	logic [15:0] rdata_ff;
	logic relay_ff;
	logic [15:0] nxt_rdata;
	logic nxt_relay;
	logic freq_hi;
	logic curr_hi;
	logic ain2_hi;

	// The five status pins from the rest of the drive are synchronised before use.
	logic [4:0] flag_meta_ff;
	logic [4:0] flag_ff;

	function automatic logic sel_hit(input logic [3:0] a, input logic [3:0] b);
		return a == b;
	endfunction

	// Writes out of range are clamped to the legal limits, not refused.
	function automatic logic [15:0] clamp_u(input logic [15:0] v,
		input logic [15:0] hi);
		return (v > hi) ? hi : v;
	endfunction

	wire logic wr_scale = reg_wr && sel_hit(reg_addr, ADDR_SCALE);
	wire logic wr_offset = reg_wr && sel_hit(reg_addr, ADDR_OFFSET);
	wire logic wr_sel = reg_wr && sel_hit(reg_addr, ADDR_RELAY_SEL);
	wire logic wr_thresh = reg_wr && sel_hit(reg_addr, ADDR_THRESH);
	wire logic wr_hyst = reg_wr && sel_hit(reg_addr, ADDR_HYST);
	wire logic wr_ctrl = reg_wr && sel_hit(reg_addr, ADDR_CTRL_SRC);

	wire logic signed [15:0] offset_s = $signed(reg_wdata);
	wire logic [15:0] offset_lim =
		(offset_s > $signed(OFFSET_MAX)) ? OFFSET_MAX :
		(offset_s < $signed(OFFSET_MIN)) ? OFFSET_MIN : reg_wdata;

	// Each setting has its own register so that a write to one address can
	// never disturb another, whatever the decode does on an unmapped index.
	// Clamping at the write bounds each setting but the control source; the comparators still guard threshold minus hysteresis below zero.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scale_ff <= SCALE_RST;
		end else if (wr_scale) begin
			scale_ff <= clamp_u(reg_wdata, SCALE_MAX);
		end
	end

	// The offset is signed, so it is clamped on both sides of zero.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			offset_ff <= OFFSET_RST;
		end else if (wr_offset) begin
			offset_ff <= offset_lim;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			relay_sel_ff <= RELAY_SEL_RST;
		end else if (wr_sel) begin
			relay_sel_ff <= clamp_u(reg_wdata, RELAY_SEL_MAX);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			thresh_ff <= THRESH_RST;
		end else if (wr_thresh) begin
			thresh_ff <= clamp_u(reg_wdata, THRESH_MAX);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hyst_ff <= HYST_RST;
		end else if (wr_hyst) begin
			hyst_ff <= clamp_u(reg_wdata, HYST_MAX);
		end
	end

	// Any source code is accepted; only the slave code changes behaviour.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_src_ff <= CTRL_SRC_RST;
		end else if (wr_ctrl) begin
			ctrl_src_ff <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_meta_ff <= 5'h00;
			flag_ff <= 5'h00;
		end else begin
			flag_meta_ff <= {drive_running, power_ok, drive_fault, at_speed,
				drive_ready};
			flag_ff <= flag_meta_ff;
		end
	end

	wire logic f_run = flag_ff[4];
	wire logic f_pwr = flag_ff[3];
	wire logic f_fault = flag_ff[2];
	wire logic f_at = flag_ff[1];
	wire logic f_rdy = flag_ff[0];

	// Analog result: (level - offset) * scale / 100.0 %, saturated to 16 bits.
	// The product can reach far beyond the result width, so it is clamped.
	wire logic signed [17:0] diff =
		$signed({2'b00, ain1_level}) - $signed({{2{offset_ff[15]}}, offset_ff});
	wire logic signed [35:0] prod =
		36'(diff) * $signed({20'h00000, scale_ff});
	wire logic signed [35:0] quot = prod / $signed({4'h0, SCALE_UNITY});
	wire logic [15:0] nxt_result =
		(quot > 36'sh00007FFF) ? 16'h7FFF :
		(quot < -36'sh00008000) ? 16'h8000 : quot[15:0];

	// Slave speed: master times factor, limited by minimum and maximum.
	wire logic [31:0] sprod = master_speed * scale_ff;
	wire logic [31:0] squot = sprod / SCALE_UNITY;
	wire logic [15:0] s_max = (squot > {16'h0000, max_speed}) ? max_speed :
		squot[15:0];
	wire logic [15:0] s_lim = (s_max < min_speed) ? min_speed : s_max;
	wire logic slave_mode = ctrl_src_ff == CTRL_SRC_SLAVE;
	wire logic [15:0] nxt_slave = slave_mode ? s_lim : 16'h0000;

	// Comparators for threshold based relay selections.
	ros_hyst_cmp u_freq (
		.clk(clk),
		.rst_b(rst_b),
		.level(out_freq_pct),
		.threshold(thresh_ff),
		.hysteresis(hyst_ff),
		.above(freq_hi)
	);
	ros_hyst_cmp u_curr (
		.clk(clk),
		.rst_b(rst_b),
		.level(motor_curr_pct),
		.threshold(thresh_ff),
		.hysteresis(hyst_ff),
		.above(curr_hi)
	);
	ros_hyst_cmp u_ain2 (
		.clk(clk),
		.rst_b(rst_b),
		.level(ain2_level),
		.threshold(thresh_ff),
		.hysteresis(hyst_ff),
		.above(ain2_hi)
	);

	wire ros_relay_sel_t rsel = ros_relay_sel_t'(relay_sel_ff[3:0]);

	// The below-threshold selections reuse the above comparators inverted,
	// so both directions share one hysteresis band and one state.
	// A selection change takes effect on the next edge with no blanking.
	always_comb begin
		case (rsel)
			ROS_RUNNING: begin
				nxt_relay = f_run;
			end
			ROS_HEALTHY: begin
				nxt_relay = f_pwr && !f_fault;
			end
			ROS_AT_SPEED: begin
				nxt_relay = f_at;
			end
			ROS_TRIPPED: begin
				nxt_relay = f_fault;
			end
			ROS_FREQ_HI: begin
				nxt_relay = freq_hi;
			end
			ROS_CURR_HI: begin
				nxt_relay = curr_hi;
			end
			ROS_FREQ_LO: begin
				nxt_relay = !freq_hi;
			end
			ROS_CURR_LO: begin
				nxt_relay = !curr_hi;
			end
			ROS_AIN2_HI: begin
				nxt_relay = ain2_hi;
			end
			ROS_READY: begin
				nxt_relay = f_rdy && !f_fault;
			end
			default: begin
				nxt_relay = 1'b0;
			end
		endcase
	end

	wire logic [15:0] status_word = {11'h000, relay_ff, slave_mode, freq_hi,
		curr_hi, ain2_hi};

	// Read-only words have no write decode, so writes to them are lost.
	always_comb begin
		case (reg_addr)
			ADDR_SCALE: begin
				nxt_rdata = scale_ff;
			end
			ADDR_OFFSET: begin
				nxt_rdata = offset_ff;
			end
			ADDR_RELAY_SEL: begin
				nxt_rdata = relay_sel_ff;
			end
			ADDR_THRESH: begin
				nxt_rdata = thresh_ff;
			end
			ADDR_HYST: begin
				nxt_rdata = hyst_ff;
			end
			ADDR_CTRL_SRC: begin
				nxt_rdata = ctrl_src_ff;
			end
			ADDR_RESULT: begin
				nxt_rdata = result_ff;
			end
			ADDR_SLAVE_SPD: begin
				nxt_rdata = slave_ff;
			end
			ADDR_STATUS: begin
				nxt_rdata = status_word;
			end
			default: begin
				nxt_rdata = 16'h0000;
			end
		endcase
	end

	// The result is recomputed every cycle; a read shows last cycle's value.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			result_ff <= 16'h0000;
		end else begin
			result_ff <= nxt_result;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slave_ff <= 16'h0000;
		end else begin
			slave_ff <= nxt_slave;
		end
	end

	// The relay output is registered so that it never glitches on a decode.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			relay_ff <= 1'b0;
		end else begin
			relay_ff <= nxt_relay;
		end
	end

	// Read data stand for one cycle only and are zero otherwise.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= reg_rd ? nxt_rdata : 16'h0000;
		end
	end

	assign reg_rdata = rdata_ff;
	assign relay_active = relay_ff;
	assign scaled_analog_result = result_ff;
	assign slave_speed = slave_ff;
endmodule

// file: testbench/ros_relay_scale_props.sv
`timescale 1ns/10ps
module ros_chk
	import ros_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [15:0] out_freq_pct,
	input wire logic [15:0] motor_curr_pct,
	input wire logic [15:0] min_speed,
	input wire logic [15:0] max_speed,
	input wire logic drive_running,
	input wire logic power_ok,
	input wire logic drive_fault,
	input wire logic relay_active,
	input wire logic [15:0] scaled_analog_result,
	input wire logic [15:0] slave_speed
);
	logic [15:0] sel_ff, thr_ff, hys_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Shadow copies of the relay settings, clamped as the port clamps them.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_ff <= RELAY_SEL_RST;
			thr_ff <= THRESH_RST;
			hys_ff <= HYST_RST;
		end else if (reg_wr && reg_addr == ADDR_RELAY_SEL)
			sel_ff <= reg_wdata > RELAY_SEL_MAX ? RELAY_SEL_MAX : reg_wdata;
		else if (reg_wr && reg_addr == ADDR_THRESH)
			thr_ff <= reg_wdata > THRESH_MAX ? THRESH_MAX : reg_wdata;
		else if (reg_wr && reg_addr == ADDR_HYST)
			hys_ff <= reg_wdata > HYST_MAX ? HYST_MAX : reg_wdata;
	end
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside read slot");
	a_result_rd: assert property
		(reg_rd && reg_addr == ADDR_RESULT |=>
		reg_rdata == $past(scaled_analog_result))
		else $error("result read differs from result port");
	a_slave_clamp: assert property
		(slave_speed != 16'h0000 && $stable(min_speed) && $stable(max_speed)
		|-> slave_speed >= min_speed && slave_speed <= max_speed)
		else $error("slave speed outside speed limits");
	a_relay_run: assert property
		((sel_ff == 16'h0000 && drive_running) [*5] |-> relay_active)
		else $error("relay open while running");
	a_relay_ok: assert property
		((sel_ff == 16'h0001 && power_ok && !drive_fault) [*5] |-> relay_active)
		else $error("relay open while healthy");
	a_relay_trip: assert property
		((sel_ff == 16'h0003 && !drive_fault) [*5] |-> !relay_active)
		else $error("relay closed without fault");
	a_freq_high: assert property
		((sel_ff == 16'h0004 && out_freq_pct > thr_ff + hys_ff) [*4]
		|-> relay_active)
		else $error("relay open with frequency above band");
	a_curr_low: assert property
		((sel_ff == 16'h0007 && motor_curr_pct + hys_ff < thr_ff) [*4]
		|-> relay_active)
		else $error("relay open with current below band");
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import ros_pkg::*;
	logic clk, rst_b, reg_wr, reg_rd, relay_active;
	logic drive_running, power_ok, drive_fault, at_speed, drive_ready;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, ain1_level, ain2_level, out_freq_pct;
	logic [15:0] motor_curr_pct, master_speed, min_speed, max_speed;
	logic [15:0] scaled_analog_result, slave_speed;
	int err_count, n_tests;
	ros_relay_scale dut (.*);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task t_regs;
		rd(ADDR_SCALE, SCALE_RST);
		rd(ADDR_OFFSET, OFFSET_RST);
		rd(ADDR_RELAY_SEL, RELAY_SEL_RST);
		rd(ADDR_THRESH, THRESH_RST);
		rd(ADDR_HYST, HYST_RST);
		rd(4'hF, 16'h0000);
		wr(ADDR_SCALE, 16'hFFFF);
		rd(ADDR_SCALE, SCALE_MAX);
		wr(ADDR_OFFSET, 16'h8000);
		rd(ADDR_OFFSET, OFFSET_MIN);
		wr(ADDR_OFFSET, 16'h1389);
		rd(ADDR_OFFSET, OFFSET_MAX);
		wr(ADDR_RELAY_SEL, 16'h000A);
		rd(ADDR_RELAY_SEL, RELAY_SEL_MAX);
		wr(ADDR_THRESH, 16'h07D1);
		rd(ADDR_THRESH, THRESH_MAX);
		wr(ADDR_HYST, 16'h03E9);
		rd(ADDR_HYST, HYST_MAX);
		$display("test regs done");
	endtask
	task ain(input logic [15:0] v, input logic [15:0] exp);
		@(posedge clk);
		ain1_level <= v;
		settle(3);
		chk(scaled_analog_result, exp);
	endtask
	task t_result;
		wr(ADDR_SCALE, 16'h07D0);
		wr(ADDR_OFFSET, 16'h0064);
		ain(16'h01F4, 16'h0320);
		rd(ADDR_RESULT, 16'h0320);
		wr(ADDR_SCALE, SCALE_RST);
		ain(16'h0032, 16'hFFCE);
		wr(ADDR_RESULT, 16'h0000);
		rd(ADDR_RESULT, 16'hFFCE);
		$display("test result done");
	endtask
	task slv(input logic [15:0] m, input logic [15:0] exp);
		@(posedge clk);
		master_speed <= m;
		settle(3);
		chk(slave_speed, exp);
	endtask
	task t_slave;
		wr(ADDR_SCALE, 16'h07D0);
		wr(ADDR_CTRL_SRC, CTRL_SRC_SLAVE);
		slv(16'h0096, 16'h012C);
		slv(16'h012C, 16'h01F4);
		slv(16'h0014, 16'h0064);
		rd(ADDR_SLAVE_SPD, 16'h0064);
		wr(ADDR_CTRL_SRC, CTRL_SRC_RST);
		slv(16'h0096, 16'h0000);
		$display("test slave done");
	endtask
	task flg(input logic [15:0] s, input logic [4:0] b, input logic e);
		wr(ADDR_RELAY_SEL, s);
		@(posedge clk);
		{drive_running, power_ok, at_speed, drive_fault, drive_ready} <= b;
		settle(6);
		chk(relay_active, e);
	endtask
	task t_flags;
		flg(16'h0000, 5'b10000, 1'b1);
		rd(ADDR_STATUS, 16'h0010);
		flg(16'h0000, 5'b01111, 1'b0);
		flg(16'h0001, 5'b01000, 1'b1);
		flg(16'h0001, 5'b01010, 1'b0);
		flg(16'h0001, 5'b00000, 1'b0);
		flg(16'h0002, 5'b00100, 1'b1);
		flg(16'h0002, 5'b11011, 1'b0);
		flg(16'h0003, 5'b00010, 1'b1);
		flg(16'h0003, 5'b11101, 1'b0);
		flg(16'h0009, 5'b00001, 1'b1);
		flg(16'h0009, 5'b00011, 1'b0);
		$display("test flags done");
	endtask
	// 1020 sits inside the 950..1050 band, so the relay must keep its state.
	task t_cmp;
		logic [15:0] v [5];
		logic e [5];
		logic x;
		v = '{16'h0000, 16'h044C, 16'h03FC, 16'h03AC, 16'h03FC};
		e = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		wr(ADDR_THRESH, THRESH_RST);
		wr(ADDR_HYST, 16'h0032);
		for (int s = 4; s <= 8; s++) begin
			wr(ADDR_RELAY_SEL, 16'(s));
			for (int i = 0; i < 5; i++) begin
				@(posedge clk);
				out_freq_pct <= v[i];
				motor_curr_pct <= v[i];
				ain2_level <= v[i];
				settle(4);
				x = e[i] ^ (s == 6 || s == 7);
				chk(relay_active, x);
				chk(relay_active, x);
			end
		end
		$display("test compare done");
	endtask
	task results;
		$display("counts: %0d compares, %0d mismatches", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		{reg_wr, reg_rd, drive_running, power_ok, at_speed} = '0;
		{drive_fault, drive_ready, reg_addr, reg_wdata} = '0;
		{ain1_level, ain2_level, out_freq_pct, motor_curr_pct} = '0;
		master_speed = 16'h0000;
		min_speed = 16'h0064;
		max_speed = 16'h01F4;
		err_count = 0;
		n_tests = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_regs;
		t_result;
		t_slave;
		t_flags;
		t_cmp;
		results;
	end
	// The tests need well under 1000 cycles; three times that means a hang.
	initial begin
		#(3000 * 100);
		err_count++;
		results;
	end
endmodule
bind ros_relay_scale ros_chk chk (.*);
